// *** core/bbce_map.svh ***
// Constants of the bit, branch and clear execution block
`ifndef BBCE_MAP_SVH
`define BBCE_MAP_SVH
`define BBCE_OP_TBS_LO 8'h00
`define BBCE_OP_TBS_HI 8'h0e
`define BBCE_OP_SMB_LO 8'h10
`define BBCE_OP_SMB_HI 8'h1e
`define BBCE_OP_SUB 8'had
`define BBCE_OP_CEQ_DIR 8'h31
`define BBCE_OP_CEQ_IMMA 8'h41
`define BBCE_OP_CEQ_IMMX 8'h51
`define BBCE_OP_CEQ_IX1P 8'h61
`define BBCE_OP_CEQ_IXP 8'h71
`define BBCE_OP_CCY 8'h98
`define BBCE_OP_UMI 8'h9a
`define BBCE_OP_ZF_DIR 8'h3f
`define BBCE_OP_ZF_A 8'h4f
`define BBCE_OP_ZF_X 8'h5f
`define BBCE_OP_ZF_H 8'h8c
`define BBCE_OP_ZF_IX1 8'h6f
`define BBCE_OP_ZF_IX 8'h7f
`define BBCE_OP_PREFIX 8'h9e
`define BBCE_CYC_TBS 4'h5
`define BBCE_CYC_SMB 4'h4
`define BBCE_CYC_SUB 4'h4
`define BBCE_CYC_CEQ_DIR 4'h5
`define BBCE_CYC_CEQ_IMM 4'h4
`define BBCE_CYC_CEQ_IX1P 4'h5
`define BBCE_CYC_CEQ_IXP 4'h4
`define BBCE_CYC_CEQ_SPO 4'h6
`define BBCE_CYC_CCY 4'h1
`define BBCE_CYC_UMI 4'h2
`define BBCE_CYC_ZF_DIR 4'h3
`define BBCE_CYC_ZF_REG 4'h1
`define BBCE_CYC_ZF_IX1 4'h3
`define BBCE_CYC_ZF_IX 4'h2
`define BBCE_CYC_ZF_SPO 4'h4
`define BBCE_LEN2 16'h0002
`define BBCE_LEN3 16'h0003
`define BBCE_LEN4 16'h0004
`define BBCE_RST_SP 16'h00ff
`define BBCE_RST_FLAGS 8'h68
`define BBCE_FLAG_C 0
`define BBCE_FLAG_Z 1
`define BBCE_FLAG_N 2
`define BBCE_FLAG_I 3
`define BBCE_FLAG_V 7
`endif

// *** core/bbce_pkg.sv ***
// Types of the bit, branch and clear execution block
`default_nettype none
package bbce_pkg;
  // Operation class picked by the decoder
  typedef enum logic [3:0] {
    BBCE_NONE = 4'h0,
    BBCE_TBS = 4'h1,
    BBCE_SMB = 4'h2,
    BBCE_SUB = 4'h3,
    BBCE_CEQ = 4'h4,
    BBCE_CCY = 4'h5,
    BBCE_UMI = 4'h6,
    BBCE_ZF = 4'h7
  } bbce_op_t;
  // Operand source of a compare or clear
  typedef enum logic [2:0] {
    BBCE_M_DIR = 3'h0,
    BBCE_M_IMM = 3'h1,
    BBCE_M_IX1 = 3'h2,
    BBCE_M_IX = 3'h3,
    BBCE_M_SPO = 3'h4,
    BBCE_M_A = 3'h5,
    BBCE_M_X = 3'h6,
    BBCE_M_H = 3'h7
  } bbce_mode_t;
  // Execution states
  typedef enum logic [1:0] {
    BBCE_S_IDLE = 2'b00,
    BBCE_S_RUN = 2'b01,
    BBCE_S_DONE = 2'b10
  } bbce_state_t;
endpackage
`default_nettype wire

// *** core/bbce_decode.sv ***
// Opcode decoder: class, mode, bit number and cycle count
`include "bbce_map.svh"
`default_nettype none
module bbce_decode (
  input wire logic prefix,
  input wire logic [7:0] opcode,
  output bbce_pkg::bbce_op_t op,
  output bbce_pkg::bbce_mode_t mode,
  output logic [2:0] bit_num,
  output logic [3:0] cycles,
  output logic use_x
);
  import bbce_pkg::*;
  // Bit number is half the low opcode nibble for both bit groups
  assign bit_num = opcode[3:1]; // [RULE_04]
  assign use_x = (opcode == `BBCE_OP_CEQ_IMMX);
  // Flat decode; the prefix selects the stack-relative forms only
  always_comb begin
    op = BBCE_NONE;
    mode = BBCE_M_DIR;
    cycles = 4'h0;
    if (prefix) begin
      if (opcode == `BBCE_OP_CEQ_IX1P) begin
        op = BBCE_CEQ; // [RULE_20]
        mode = BBCE_M_SPO;
        cycles = `BBCE_CYC_CEQ_SPO; // [RULE_13]
      end else if (opcode == `BBCE_OP_ZF_IX1) begin
        op = BBCE_ZF;
        mode = BBCE_M_SPO;
        cycles = `BBCE_CYC_ZF_SPO; // [RULE_18]
      end
    end else if (opcode <= `BBCE_OP_TBS_HI && !opcode[0]) begin
      op = BBCE_TBS; // [RULE_04]
      cycles = `BBCE_CYC_TBS;
    end else if (opcode >= `BBCE_OP_SMB_LO && opcode <= `BBCE_OP_SMB_HI && !opcode[0]) begin
      op = BBCE_SMB; // [RULE_06]
      cycles = `BBCE_CYC_SMB;
    end else begin
      unique case (opcode)
        `BBCE_OP_SUB: begin op = BBCE_SUB; cycles = `BBCE_CYC_SUB; end // [RULE_08]
        `BBCE_OP_CEQ_DIR: begin op = BBCE_CEQ; cycles = `BBCE_CYC_CEQ_DIR; end // [RULE_13]
        `BBCE_OP_CEQ_IMMA,
        `BBCE_OP_CEQ_IMMX: begin
          op = BBCE_CEQ;
          mode = BBCE_M_IMM;
          cycles = `BBCE_CYC_CEQ_IMM;
        end
        `BBCE_OP_CEQ_IX1P: begin
          op = BBCE_CEQ;
          mode = BBCE_M_IX1;
          cycles = `BBCE_CYC_CEQ_IX1P;
        end
        `BBCE_OP_CEQ_IXP: begin op = BBCE_CEQ; mode = BBCE_M_IX; cycles = `BBCE_CYC_CEQ_IXP; end
        `BBCE_OP_CCY: begin op = BBCE_CCY; cycles = `BBCE_CYC_CCY; end // [RULE_14]
        `BBCE_OP_UMI: begin op = BBCE_UMI; cycles = `BBCE_CYC_UMI; end // [RULE_15]
        `BBCE_OP_ZF_DIR: begin op = BBCE_ZF; cycles = `BBCE_CYC_ZF_DIR; end // [RULE_18]
        `BBCE_OP_ZF_A: begin op = BBCE_ZF; mode = BBCE_M_A; cycles = `BBCE_CYC_ZF_REG; end
        `BBCE_OP_ZF_X: begin op = BBCE_ZF; mode = BBCE_M_X; cycles = `BBCE_CYC_ZF_REG; end
        `BBCE_OP_ZF_H: begin op = BBCE_ZF; mode = BBCE_M_H; cycles = `BBCE_CYC_ZF_REG; end
        `BBCE_OP_ZF_IX1: begin op = BBCE_ZF; mode = BBCE_M_IX1; cycles = `BBCE_CYC_ZF_IX1; end
        `BBCE_OP_ZF_IX: begin op = BBCE_ZF; mode = BBCE_M_IX; cycles = `BBCE_CYC_ZF_IX; end
        default: begin op = BBCE_NONE; end // Opcodes of other groups
      endcase
    end
  end
endmodule
`default_nettype wire

// *** core/bbce_target.sv ***
// Branch target adder with sign-extended displacement
`default_nettype none
module bbce_target (
  input wire logic [15:0] base_pc,
  input wire logic [15:0] length,
  input wire logic [7:0] disp,
  output logic [15:0] fall_pc,
  output logic [15:0] taken_pc
);
  // Displacement is widened with its sign before the add
  wire [15:0] disp_ext = {{8{disp[7]}}, disp}; // [RULE_19]
  assign fall_pc = base_pc + length;
  assign taken_pc = fall_pc + disp_ext;
endmodule
`default_nettype wire

// *** core/bbce_exec.sv ***
// Execution unit for the bit, branch, compare and clear instruction group
`include "bbce_map.svh"
`default_nettype none
// Notes on behaviour
// [RULE_01] Bit one: branch to pc+3 plus displacement
// [RULE_02] Tested bit copied to carry, always
// [RULE_03] Bit operands use one-byte direct page address
// [RULE_04] Bit test opcodes even 00-0E, five cycles
// [RULE_05] Bit set changes one bit, no flags
// [RULE_06] Bit set is read-modify-write, opcodes 10-1E, four cycles
// [RULE_07] Subroutine branch pushes low then high return byte
// [RULE_08] Then adds displacement; opcode AD, four cycles
// [RULE_09] Compare A or X with memory, flags untouched
// [RULE_10] Target length three, two or four by mode
// [RULE_11] Post-increment forms bump index pair always
// [RULE_12] Offset form address is index plus unsigned byte
// [RULE_13] Compare-branch opcodes and cycle counts as listed
// [RULE_14] Clear carry, opcode 98, one cycle
// [RULE_15] Mask cleared at end of its cycle, 9A
// [RULE_16] Next instruction runs before any pending interrupt; code holds it off only if the mask was set before 9A
// [RULE_17] Clear writes zero; V,N zero, Z one
// [RULE_18] Clear opcodes and cycle counts as listed
// [RULE_19] Displacement sign-extended to sixteen bits
// [RULE_20] Prefix 9E selects stack pointer as base
module bbce_exec (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic start, // Pulse: execute the instruction below
  input wire logic prefix, // Instruction carried the 9E prefix
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1, // dd, ii, ff or rr
  input wire logic [7:0] operand2, // rr when present
  input wire logic [15:0] pc_in, // Address of the opcode byte
  input wire logic [7:0] acc_in,
  input wire logic [15:0] hx_in,
  input wire logic [15:0] sp_in,
  input wire logic [7:0] flags_in,
  input wire logic irq_pending,
  input wire logic [7:0] mem_rdata, // Read data, valid in the cycle mem_rd is high
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_rd,
  output logic mem_wr,
  output logic busy,
  output logic done, // Pulse: results below are final
  output logic [15:0] pc_out,
  output logic [7:0] acc_out,
  output logic [15:0] hx_out,
  output logic [15:0] sp_out,
  output logic [7:0] flags_out,
  output logic irq_inhibit, // Hold off interrupt entry before next instruction
  output logic illegal // Pulse: opcode belongs to another group
);
  import bbce_pkg::*;

  // Reset release through two flops
  logic rst_s1_ff, rst_s2_ff;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire rst_n = rst_s2_ff;

  // Decoder of the incoming opcode
  bbce_op_t dec_op;
  bbce_mode_t dec_mode;
  logic [2:0] dec_bit;
  logic [3:0] dec_cyc;
  logic dec_use_x;
  bbce_decode u_dec (
    .prefix(prefix),
    .opcode(opcode),
    .op(dec_op),
    .mode(dec_mode),
    .bit_num(dec_bit),
    .cycles(dec_cyc),
    .use_x(dec_use_x)
  );

  // Latched instruction context
  bbce_state_t state_ff;
  bbce_op_t op_ff;
  bbce_mode_t mode_ff;
  logic [2:0] bit_ff;
  logic [3:0] cyc_ff; // Cycles left in the instruction
  logic use_x_ff;
  logic [7:0] opd1_ff, opd2_ff;
  logic [15:0] opc_pc_ff;
  logic [7:0] mdata_ff; // Captured memory byte
  logic [1:0] step_ff; // Bus step inside the instruction

  // Result registers (outputs)
  logic [15:0] mem_addr_ff, pc_ff, hx_ff, sp_ff;
  logic [7:0] mem_wdata_ff, acc_ff, flags_ff;
  logic mem_rd_ff, mem_wr_ff, done_ff, inhibit_ff, illegal_ff, busy_ff;

  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign mem_rd = mem_rd_ff;
  assign mem_wr = mem_wr_ff;
  assign busy = busy_ff;
  assign done = done_ff;
  assign pc_out = pc_ff;
  assign acc_out = acc_ff;
  assign hx_out = hx_ff;
  assign sp_out = sp_ff;
  assign flags_out = flags_ff;
  assign irq_inhibit = inhibit_ff;
  assign illegal = illegal_ff;

  // Effective address per mode; offsets are unsigned bytes
  wire [15:0] dir_addr = {8'h00, opd1_ff}; // [RULE_03]
  wire [15:0] ix1_addr = hx_ff + {8'h00, opd1_ff}; // [RULE_12]
  wire [15:0] spo_addr = sp_ff + {8'h00, opd1_ff}; // [RULE_20]
  wire [15:0] eff_addr = (mode_ff == BBCE_M_IX1) ? ix1_addr :
                         (mode_ff == BBCE_M_IX) ? hx_ff :
                         (mode_ff == BBCE_M_SPO) ? spo_addr : dir_addr;

  // Instruction length and displacement for branch targets
  wire [15:0] ins_len = (op_ff == BBCE_SUB || op_ff == BBCE_SMB) ? `BBCE_LEN2 :
                        (mode_ff == BBCE_M_IX) ? `BBCE_LEN2 : // [RULE_10]
                        (mode_ff == BBCE_M_SPO) ? `BBCE_LEN4 : `BBCE_LEN3;
  wire [7:0] disp = (mode_ff == BBCE_M_IX) ? opd1_ff :
                    (op_ff == BBCE_SUB) ? opd1_ff : opd2_ff;
  logic [15:0] fall_pc, taken_pc;
  bbce_target u_tgt (
    .base_pc(opc_pc_ff),
    .length(ins_len),
    .disp(disp),
    .fall_pc(fall_pc),
    .taken_pc(taken_pc)
  );

  // Test and compare results
  wire test_bit = mdata_ff[bit_ff]; // [RULE_01]
  wire [7:0] cmp_reg = use_x_ff ? hx_ff[7:0] : acc_ff; // [RULE_09]
  wire [7:0] cmp_mem = (mode_ff == BBCE_M_IMM) ? opd1_ff : mdata_ff;
  wire cmp_eq = (cmp_reg == cmp_mem); // [RULE_09]
  wire [7:0] set_byte = mdata_ff | (8'h01 << bit_ff); // [RULE_05]
  wire needs_read = (op_ff == BBCE_TBS) || (op_ff == BBCE_SMB) ||
                    ((op_ff == BBCE_CEQ) && (mode_ff != BBCE_M_IMM));
  wire zf_mem = (op_ff == BBCE_ZF) && (mode_ff != BBCE_M_A) &&
                (mode_ff != BBCE_M_X) && (mode_ff != BBCE_M_H);
  wire last_cyc = (cyc_ff == 4'h1);

  // Control: accept, count cycles, finish
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= BBCE_S_IDLE;
      op_ff <= BBCE_NONE;
      mode_ff <= BBCE_M_DIR;
      bit_ff <= 3'h0;
      cyc_ff <= 4'h0;
      use_x_ff <= 1'b0;
      opd1_ff <= 8'h00;
      opd2_ff <= 8'h00;
      opc_pc_ff <= 16'h0000;
      step_ff <= 2'h0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
      unique case (state_ff)
        BBCE_S_IDLE: begin
          if (start && dec_op == BBCE_NONE) begin
            illegal_ff <= 1'b1; // Not ours; leave state alone
          end else if (start) begin
            state_ff <= BBCE_S_RUN;
            op_ff <= dec_op;
            mode_ff <= dec_mode;
            bit_ff <= dec_bit;
            cyc_ff <= dec_cyc;
            use_x_ff <= dec_use_x;
            opd1_ff <= operand1;
            opd2_ff <= operand2;
            opc_pc_ff <= pc_in;
            step_ff <= 2'h0;
            busy_ff <= 1'b1; // Registered copy of state not idle
          end
        end
        BBCE_S_RUN: begin
          cyc_ff <= cyc_ff - 4'h1;
          step_ff <= (step_ff == 2'h3) ? step_ff : step_ff + 2'h1;
          if (last_cyc) begin
            state_ff <= BBCE_S_DONE;
          end
        end
        BBCE_S_DONE: begin
          done_ff <= 1'b1;
          state_ff <= BBCE_S_IDLE;
          busy_ff <= 1'b0;
        end
        default: state_ff <= BBCE_S_IDLE;
      endcase
    end
  end

  // Memory bus: read at step 0, capture at step 1; set-bit write at step 2, clear and push writes from step 0
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 8'h00;
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      mdata_ff <= 8'h00;
    end else begin
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      if (state_ff == BBCE_S_RUN) begin
        if (step_ff == 2'h0 && needs_read) begin
          mem_addr_ff <= eff_addr; // [RULE_03]
          mem_rd_ff <= 1'b1;
        end
        if (step_ff == 2'h1) begin
          mdata_ff <= mem_rdata;
        end
        if (step_ff == 2'h2 && op_ff == BBCE_SMB) begin
          mem_addr_ff <= dir_addr; // Whole byte written back [RULE_06]
          mem_wdata_ff <= set_byte; // [RULE_05]
          mem_wr_ff <= 1'b1;
        end
        if (step_ff == 2'h0 && zf_mem) begin
          mem_addr_ff <= eff_addr;
          mem_wdata_ff <= 8'h00; // [RULE_17]
          mem_wr_ff <= 1'b1;
        end
        if (op_ff == BBCE_SUB && step_ff == 2'h0) begin
          mem_addr_ff <= sp_ff;
          mem_wdata_ff <= fall_pc[7:0]; // Low return byte first [RULE_07]
          mem_wr_ff <= 1'b1;
        end
        if (op_ff == BBCE_SUB && step_ff == 2'h1) begin
          mem_addr_ff <= sp_ff;
          mem_wdata_ff <= fall_pc[15:8]; // [RULE_07]
          mem_wr_ff <= 1'b1;
        end
      end
    end
  end

  // Architectural results: pc, registers, flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= 16'h0000;
      acc_ff <= 8'h00;
      hx_ff <= 16'h0000;
      sp_ff <= `BBCE_RST_SP;
      flags_ff <= `BBCE_RST_FLAGS;
      inhibit_ff <= 1'b0;
    end else if (state_ff == BBCE_S_IDLE && start) begin
      acc_ff <= acc_in;
      hx_ff <= hx_in;
      sp_ff <= sp_in;
      flags_ff <= flags_in;
      inhibit_ff <= 1'b0;
    end else if (state_ff == BBCE_S_RUN) begin
      // Stack pointer drops once per push
      if (op_ff == BBCE_SUB && step_ff != 2'h2 && step_ff != 2'h3) begin
        sp_ff <= sp_ff - 16'h0001; // [RULE_07]
      end
      if (last_cyc) begin
        unique case (op_ff)
          BBCE_TBS: begin
            flags_ff[`BBCE_FLAG_C] <= test_bit; // [RULE_02]
            pc_ff <= test_bit ? taken_pc : fall_pc; // [RULE_01]
          end
          BBCE_SUB: pc_ff <= taken_pc; // [RULE_08]
          BBCE_CEQ: begin
            pc_ff <= cmp_eq ? taken_pc : fall_pc; // [RULE_10]
            if (mode_ff == BBCE_M_IX || mode_ff == BBCE_M_IX1) begin
              hx_ff <= hx_ff + 16'h0001; // Taken or not [RULE_11]
            end
          end
          BBCE_CCY: begin
            flags_ff[`BBCE_FLAG_C] <= 1'b0; // [RULE_14]
            pc_ff <= opc_pc_ff + 16'h0001;
          end
          BBCE_UMI: begin
            // Mask drops only as the cycle ends; hold off entry only if the mask was set
            flags_ff[`BBCE_FLAG_I] <= 1'b0; // [RULE_15]
            inhibit_ff <= flags_ff[`BBCE_FLAG_I]; // [RULE_16]
            pc_ff <= opc_pc_ff + 16'h0001;
          end
          BBCE_ZF: begin
            flags_ff[`BBCE_FLAG_V] <= 1'b0; // [RULE_17]
            flags_ff[`BBCE_FLAG_N] <= 1'b0;
            flags_ff[`BBCE_FLAG_Z] <= 1'b1;
            if (mode_ff == BBCE_M_A) acc_ff <= 8'h00;
            if (mode_ff == BBCE_M_X) hx_ff[7:0] <= 8'h00;
            if (mode_ff == BBCE_M_H) hx_ff[15:8] <= 8'h00;
            pc_ff <= opc_pc_ff + ((mode_ff == BBCE_M_IX) ? 16'h0001 :
                     (mode_ff == BBCE_M_SPO) ? 16'h0003 :
                     (zf_mem) ? 16'h0002 : 16'h0001);
          end
          default: pc_ff <= fall_pc;
        endcase
      end
    end else if (state_ff == BBCE_S_IDLE && irq_pending && !inhibit_ff) begin
      inhibit_ff <= 1'b0;
    end
  end

  // Set-bit write keeps other bits and flags
  a_smb_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_05]
    (mem_wr_ff && op_ff == BBCE_SMB) |-> (mem_wdata_ff == set_byte && $stable(flags_ff)))
    else $error("set-bit write wrong");
  a_tbs_carry: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_02]
    (state_ff == BBCE_S_RUN && last_cyc && op_ff == BBCE_TBS) |=>
      (flags_ff[`BBCE_FLAG_C] == $past(test_bit)))
    else $error("carry not tested bit");
  a_bit_dirpage: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_03]
    (mem_rd_ff && (op_ff == BBCE_TBS || op_ff == BBCE_SMB)) |-> (mem_addr_ff[15:8] == 8'h00))
    else $error("bit operand off page zero");
  a_sub_push: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_07]
    (mem_wr_ff && op_ff == BBCE_SUB && step_ff == 2'h1) |->
      (mem_wdata_ff == fall_pc[7:0]) ##1 (mem_wr_ff && mem_wdata_ff == fall_pc[15:8]))
    else $error("return bytes pushed out of order");
  a_ceq_flags: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_09]
    (state_ff == BBCE_S_RUN && op_ff == BBCE_CEQ) |=> $stable(flags_ff))
    else $error("compare changed flags");
  a_ceq_incr: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_11]
    (state_ff == BBCE_S_RUN && last_cyc && op_ff == BBCE_CEQ && mode_ff == BBCE_M_IX) |=>
      (hx_ff == $past(hx_ff) + 16'h0001))
    else $error("index not incremented");
  a_ccy_carry: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_14]
    (state_ff == BBCE_S_RUN && op_ff == BBCE_CCY) |=> (!flags_ff[`BBCE_FLAG_C] ##1 done_ff))
    else $error("clear carry wrong");
  a_zf_flags: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_17]
    (state_ff == BBCE_S_DONE && op_ff == BBCE_ZF) |->
      (flags_ff[`BBCE_FLAG_Z] && !flags_ff[`BBCE_FLAG_N] && !flags_ff[`BBCE_FLAG_V]))
    else $error("clear flags wrong");
endmodule
`default_nettype wire

// *** dv/bbce_mem_model.sv ***
// Behavioural memory and I/O space on the execution unit's bus
`default_nettype none
module bbce_mem_model (
  input wire logic sys_clk,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535]; // Whole space, loaded by the bench
  logic [7:0] junk_ff = 8'h00; // Shown while no read is asked for
  // Read data stands in the cycle of the request; a toggling value otherwise
  assign mem_rdata = mem_rd ? mem[mem_addr] : junk_ff;
  // Writes land on the edge that ends the mem_wr cycle
  always @(posedge sys_clk) begin
    junk_ff <= ~junk_ff;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule
`default_nettype wire

// *** dv/test_bit_branch_clear_exec.sv ***
// Self-checking bench for the bit, branch, compare and clear execution unit
`default_nettype none
module test_bit_branch_clear_exec;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] pc0 = 16'h3000; // Opcode address for every run
  localparam logic [15:0] hx0 = 16'h0320; // Index pair at start
  localparam logic [15:0] sp0 = 16'h00a0; // Stack pointer at start
  localparam logic [7:0] a0 = 8'h5c; // Accumulator at start
  localparam logic [7:0] f0 = 8'h2d; // Flags: C, I and N set, V and Z clear
  logic sys_clk, rstn, start, prefix, irq_pending;
  logic [7:0] opcode, operand1, operand2, acc_in, flags_in, mem_rdata, mem_wdata;
  logic [15:0] pc_in, hx_in, sp_in, mem_addr, pc_out, hx_out, sp_out;
  logic [7:0] acc_out, flags_out;
  logic mem_rd, mem_wr, busy, done, irq_inhibit, illegal;
  int bad_count = 0;
  int total_checks = 0;
  int cyc_count = 0;
  bbce_exec DUT (
    .sys_clk(sys_clk), .rstn(rstn), .start(start), .prefix(prefix), .opcode(opcode),
    .operand1(operand1), .operand2(operand2), .pc_in(pc_in), .acc_in(acc_in),
    .hx_in(hx_in), .sp_in(sp_in), .flags_in(flags_in), .irq_pending(irq_pending),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .busy(busy), .done(done), .pc_out(pc_out), .acc_out(acc_out),
    .hx_out(hx_out), .sp_out(sp_out), .flags_out(flags_out), .irq_inhibit(irq_inhibit),
    .illegal(illegal)
  );
  bbce_mem_model mem_u (
    .sys_clk(sys_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_rdata(mem_rdata)
  );
  // Free-running 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc_count++;
    if (cyc_count == 4000) begin
      bad_count++;
      $display("mismatch run_cycles expected below 4000 seen 4000");
      test_done();
    end
  end
  // Compare one value; four-state so an unknown never matches
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Issue one instruction, then time done against the documented count plus one
  task automatic run(input logic pre, input logic [7:0] op, o1, o2, fl, input int n);
    int k;
    prefix = pre;
    opcode = op;
    operand1 = o1;
    operand2 = o2;
    flags_in = fl;
    start = 1'b1;
    @(posedge sys_clk);
    #1;
    start = 1'b0;
    chk("busy", 16'h0001, busy);
    k = 0;
    // Bounded wait so a lost done cannot stall the run
    while (done !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk("cycles", 16'(n + 1), 16'(k));
    chk("busy_end", 16'h0000, busy);
  endtask
  // Bit test on every bit, top of the direct page, carry preset opposite
  task automatic test_bits();
    logic [7:0] v;
    logic b;
    for (int n = 0; n < 8; n++) begin
      b = ~n[0];
      v = b ? (8'h01 << n) : ~(8'h01 << n);
      mem_u.mem[16'h00f8 + n] = v;
      run(1'b0, 8'(2 * n), 8'(8'hf8 + n), 8'hf6, {f0[7:1], ~b}, 5);
      chk("tbs_pc", b ? pc0 + 16'h0003 + 16'hfff6 : pc0 + 16'h0003, pc_out);
      chk("tbs_flags", {f0[7:1], b}, flags_out);
    end
    $display("test bit_test finished");
  endtask
  // Bit set on every bit; the rest of the byte must survive the write-back
  task automatic test_set();
    logic [7:0] v;
    for (int n = 0; n < 8; n++) begin
      v = n[0] ? 8'h00 : ~(8'h01 << n);
      mem_u.mem[16'h0060 + n] = v;
      run(1'b0, 8'(8'h10 + 2 * n), 8'(8'h60 + n), 8'h00, f0, 4);
      chk("smb_mem", v | (8'h01 << n), mem_u.mem[16'h0060 + n]);
      chk("smb_flags", f0, flags_out);
      chk("smb_pc", pc0 + 16'h0002, pc_out);
    end
    $display("test bit_set finished");
  endtask
  // Subroutine branch with a backward displacement
  task automatic test_sub();
    run(1'b0, 8'had, 8'hf0, 8'h00, f0, 4);
    chk("sub_low", 8'h02, mem_u.mem[sp0]);
    chk("sub_high", 8'h30, mem_u.mem[sp0 - 16'h0001]);
    chk("sub_sp", sp0 - 16'h0002, sp_out);
    chk("sub_pc", pc0 + 16'h0002 + 16'hfff0, pc_out);
    chk("sub_flags", f0, flags_out);
    $display("test subroutine finished");
  endtask
  // One compare-and-branch form, operand placed at its effective address
  task automatic ceq(input logic pre, input logic [7:0] op, o1, o2, input logic [15:0] ma,
                     input logic [7:0] mv, input int n, input logic [15:0] len,
                     input logic post, eq);
    mem_u.mem[ma] = mv;
    run(pre, op, o1, o2, f0, n);
    chk("ceq_pc", eq ? pc0 + len + 16'h0008 : pc0 + len, pc_out);
    chk("ceq_hx", post ? hx0 + 16'h0001 : hx0, hx_out);
    chk("ceq_flags", f0, flags_out);
    chk("ceq_acc", a0, acc_out);
  endtask
  // Every compare form, unequal then equal; offsets above 7f catch sign slips
  task automatic test_cmp();
    logic [7:0] v;
    for (int e = 0; e < 2; e++) begin
      v = e[0] ? a0 : 8'h33;
      ceq(1'b0, 8'h31, 8'h44, 8'h08, 16'h0044, v, 5, 16'h0003, 1'b0, e[0]);
      ceq(1'b0, 8'h41, v, 8'h08, 16'h0000, 8'h00, 4, 16'h0003, 1'b0, e[0]);
      ceq(1'b0, 8'h51, e[0] ? hx0[7:0] : a0, 8'h08, 16'h0000, 8'h00, 4, 16'h0003, 1'b0,
          e[0]);
      ceq(1'b0, 8'h61, 8'hf0, 8'h08, hx0 + 16'h00f0, v, 5, 16'h0003, 1'b1, e[0]);
      ceq(1'b0, 8'h71, 8'h08, 8'h00, hx0, v, 4, 16'h0002, 1'b1, e[0]);
      ceq(1'b1, 8'h61, 8'h85, 8'h08, sp0 + 16'h0085, v, 6, 16'h0004, 1'b0, e[0]);
    end
    $display("test compare finished");
  endtask
  // One clear form; a marker byte shows whether memory was touched
  task automatic zf(input logic pre, input logic [7:0] op, o1, input logic [15:0] ma,
                    input int n, input logic [15:0] len, input logic mform);
    mem_u.mem[ma] = 8'hc3;
    run(pre, op, o1, 8'h00, f0, n);
    chk("zf_mem", mform ? 8'h00 : 8'hc3, mem_u.mem[ma]);
    chk("zf_acc", op == 8'h4f ? 8'h00 : a0, acc_out);
    chk("zf_hx", {op == 8'h8c ? 8'h00 : hx0[15:8], op == 8'h5f ? 8'h00 : hx0[7:0]},
        hx_out);
    chk("zf_flags", (f0 & 8'h7b) | 8'h02, flags_out);
    chk("zf_pc", pc0 + len, pc_out);
  endtask
  // All clear forms
  task automatic test_clear();
    zf(1'b0, 8'h3f, 8'h50, 16'h0050, 3, 16'h0002, 1'b1);
    zf(1'b0, 8'h4f, 8'h00, 16'h0051, 1, 16'h0001, 1'b0);
    zf(1'b0, 8'h5f, 8'h00, 16'h0051, 1, 16'h0001, 1'b0);
    zf(1'b0, 8'h8c, 8'h00, 16'h0051, 1, 16'h0001, 1'b0);
    zf(1'b0, 8'h6f, 8'h90, hx0 + 16'h0090, 3, 16'h0002, 1'b1);
    zf(1'b0, 8'h7f, 8'h00, hx0, 2, 16'h0001, 1'b1);
    zf(1'b1, 8'h6f, 8'h90, sp0 + 16'h0090, 4, 16'h0003, 1'b1);
    $display("test clear finished");
  endtask
  // Carry and mask clears, with a pending interrupt held off after an unmask
  task automatic test_flags();
    irq_pending = 1'b1;
    run(1'b0, 8'h9a, 8'h00, 8'h00, f0, 2);
    chk("umi_flags", f0 & 8'hf7, flags_out);
    chk("umi_inhibit", 16'h0001, irq_inhibit);
    run(1'b0, 8'h98, 8'h00, 8'h00, 8'hff, 1);
    chk("ccy_flags", 8'hfe, flags_out);
    chk("ccy_inhibit", 16'h0000, irq_inhibit);
    run(1'b0, 8'h9a, 8'h00, 8'h00, f0 & 8'hf7, 2);
    chk("umi_unmasked", 16'h0000, irq_inhibit);
    irq_pending = 1'b0;
    $display("test flag_clear finished");
  endtask
  // An opcode of another group is refused with a one-cycle flag
  task automatic test_bad();
    logic seen;
    seen = 1'b0;
    opcode = 8'h01;
    start = 1'b1;
    @(posedge sys_clk);
    #1;
    start = 1'b0;
    repeat (2) begin
      seen = seen | (illegal === 1'b1);
      @(posedge sys_clk);
      #1;
    end
    chk("illegal", 16'h0001, seen);
    $display("test refused finished");
  endtask
  // Counts, verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Main sequence: reset for twelve cycles, let the synchroniser settle, then test
  initial begin
    rstn = 1'b0;
    start = 1'b0;
    prefix = 1'b0;
    opcode = 8'h00;
    operand1 = 8'h00;
    operand2 = 8'h00;
    pc_in = pc0;
    acc_in = a0;
    hx_in = hx0;
    sp_in = sp0;
    flags_in = f0;
    irq_pending = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    test_bits();
    test_set();
    test_sub();
    test_cmp();
    test_clear();
    test_flags();
    test_bad();
    test_done();
  end
endmodule
`default_nettype wire
